/* File: verilog/srrc_pkg.sv */
// constants and types of the sensor row readout and configuration block
//
// Contract
// - column stage tracks row data while hold is high, then keeps it
// - row start bits 1-10, column start 14-23, dac level 25-31, lsb lowest
// - bit 0 one scans rows bottom to top, zero top to bottom
// - bit 13 zero scans columns left to right, one reverse
// - bit 11 averaging, bit 12 subsampling, bit 24 output count; zero word defaults
// - serial data shifts on shift clock; load strobe takes over the word
// - device drives shift-end output to check the serial chain
// - line sync initialises column address to configured start
// - pixel pair clock advances column selection once line sync seen
// - device drives line end output when column scan reaches line end
// - effective row and column starts are field values times two
// - pixel rate twice pair clock; first pixel while high, next while low
// - frame sync dominates and reinitialises row address on row clock edge
package srrc_pkg;
  localparam int CFG_W      = 32;
  localparam int YDIR_BIT   = 0;
  localparam int YADDR_LSB  = 1;
  localparam int FIELD_W    = 10;
  localparam int XAVG_BIT   = 11;
  localparam int XSUB_BIT   = 12;
  localparam int XDIR_BIT   = 13;
  localparam int XADDR_LSB  = 14;
  localparam int NOUT_BIT   = 24;
  localparam int DAC_LSB    = 25;
  localparam int DAC_W      = 7;
  localparam int ADDR_W     = 11;
  localparam logic [ADDR_W-1:0] ADDR_MAX  = 11'h7FF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
  localparam logic [ADDR_W-1:0] ROW_STEP  = 11'h001;
  localparam logic [ADDR_W-1:0] PAIR_STEP = 11'h002;
  localparam logic [ADDR_W-1:0] SUB_STEP  = 11'h004;
  localparam logic [CFG_W-1:0]  CFG_RESET = 32'h0000_0000;
  localparam logic [5:0]        SPI_BITS  = 6'h20;
  localparam int CLK_NS     = 20;
  localparam int SH_MIN_NS  = 100;
  localparam int SH_MAX_NS  = 200;
  localparam int SH_MIN_CYC = (SH_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SH_MAX_CYC = SH_MAX_NS / CLK_NS;
  localparam int ROT_W      = 8;
  localparam logic [ROT_W-1:0] ROT_ZERO = 8'h00;
  localparam logic [ROT_W-1:0] ROT_ONE  = 8'h01;
  localparam logic [ROT_W-1:0] ROT_TOP  = 8'hFF;
  typedef enum logic {ROT_STANDARD, ROT_SAMPLE_HOLD} srrc_rot_t;
  typedef enum logic [1:0] {RP_IDLE, RP_TRACK, RP_HELD, RP_READ} srrc_row_t;
endpackage

/* File: verilog/srrc_top.sv */
// pixel address fifo and sensor row readout and configuration logic
`timescale 1ns/1ps
module srrc_fifo #(
  parameter int W     = 12,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid_ff,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data_ff
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;
  assign in_ready = cnt_ff < (AW+1)'(DEPTH);
  assign push = in_valid && in_ready;
  assign pop  = (cnt_ff != '0) && (!out_valid_ff || out_ready);
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + AW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + AW'(1);
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // output register keeps the port straight from a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= mem[rd_ptr_ff];
    end else if (out_ready) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule // srrc_fifo

module srrc_top #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        spi_clock,
  input  wire logic                        spi_data,
  input  wire logic                        spi_load,
  input  wire logic                        sync_y,
  input  wire logic                        clock_y,
  input  wire logic                        sync_x,
  input  wire logic                        clock_x,
  input  wire logic                        column_sample_hold,
  input  wire logic                        pre_col,
  input  wire logic                        norowsel,
  input  wire logic                        volt_avg,
  input  wire logic                        bus_precharge_a,
  input  wire logic                        bus_precharge_b,
  input  wire logic                        pix_ready,
  output logic                             spi_end_ff,
  output logic                             spi_count_err_ff,
  output logic [srrc_pkg::CFG_W-1:0]       cfg_ff,
  output logic [srrc_pkg::ADDR_W-1:0]      row_addr_ff,
  output logic                             frame_end_ff,
  output logic [srrc_pkg::ADDR_W-1:0]      col_addr_ff,
  output logic                             line_end_ff,
  output logic                             pixel_phase_ff,
  output logic                             overrun_ff,
  output logic                             column_tracking_ff,
  output srrc_pkg::srrc_rot_t              rot_mode_ff,
  output logic [srrc_pkg::ROT_W-1:0]       row_overhead_time_ff,
  output logic                             hold_range_err_ff,
  output logic                             avg_apply_ff,
  output logic                             avg_refused_ff,
  output logic                             bus_precharged_ff,
  output logic                             pix_valid_ff,
  output logic [srrc_pkg::ADDR_W:0]        pix_data_ff
);
  localparam int NS = 13;
  logic [NS-1:0] s1_ff;
  logic [NS-1:0] s2_ff;
  logic [NS-1:0] s3_ff;
  logic [NS-1:0] rise;
  logic sck, sdat, sld, sy, cy, sx, cx, sh, pc, nrs, va, pa, pb;
  logic sck_r, sdat_r, sld_r, sy_r, cy_r, sx_r, cx_r, sh_r, pc_r, nrs_r, va_r, pa_r, pb_r;
  logic [srrc_pkg::CFG_W-1:0] shift_ff;
  logic [5:0]                 bits_ff;
  srrc_pkg::srrc_row_t        row_st_ff;
  logic [srrc_pkg::ROT_W-1:0] hold_cnt_ff;
  logic                       armed_ff;
  logic                       fifo_ready;
  logic                       col_go;
  logic [srrc_pkg::ADDR_W-1:0] row_start;
  logic [srrc_pkg::ADDR_W-1:0] col_start;
  logic [srrc_pkg::ADDR_W-1:0] col_step;
  logic                        hold_fall;
  logic [srrc_pkg::ADDR_W-1:0] col_next;

  // every pin but reset and pix_ready crosses two flops; the bus precharge pulse is only seen if wider than a clk period
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= {spi_clock, spi_data, spi_load, sync_y, clock_y, sync_x, clock_x,
                column_sample_hold, pre_col, norowsel, volt_avg, bus_precharge_a, bus_precharge_b};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  assign rise = s2_ff & ~s3_ff;
  assign {sck, sdat, sld, sy, cy, sx, cx, sh, pc, nrs, va, pa, pb} = s2_ff;
  assign {sck_r, sdat_r, sld_r, sy_r, cy_r, sx_r, cx_r, sh_r, pc_r, nrs_r, va_r, pa_r, pb_r} = rise;
  assign hold_fall = s3_ff[NS-8] & ~sh;

  // field decode
  assign row_start = {cfg_ff[srrc_pkg::YADDR_LSB +: srrc_pkg::FIELD_W], 1'b0};
  assign col_start = {cfg_ff[srrc_pkg::XADDR_LSB +: srrc_pkg::FIELD_W], 1'b0};
  assign col_step  = cfg_ff[srrc_pkg::XSUB_BIT] ? srrc_pkg::SUB_STEP : srrc_pkg::PAIR_STEP;
  assign col_next  = cfg_ff[srrc_pkg::XDIR_BIT] ? col_addr_ff - col_step : col_addr_ff + col_step;

  // serial chain: bit 0 enters first and ends at the lsb after 32 clocks
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_ff   <= srrc_pkg::CFG_RESET;
      bits_ff    <= '0;
      spi_end_ff <= 1'b0;
    end else if (sld_r) begin
      bits_ff <= '0;
    end else if (sck_r && !sld) begin
      shift_ff   <= {sdat, shift_ff[srrc_pkg::CFG_W-1:1]};
      spi_end_ff <= shift_ff[0];
      // saturates one past the word so a surplus bit still flags
      bits_ff    <= (bits_ff > srrc_pkg::SPI_BITS) ? bits_ff : bits_ff + 6'h01;
    end
  end

  // a miscounted word is still taken; the flag only tells the controller
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_ff           <= srrc_pkg::CFG_RESET;
      spi_count_err_ff <= 1'b0;
    end else if (sld_r) begin
      cfg_ff           <= shift_ff;
      spi_count_err_ff <= bits_ff != srrc_pkg::SPI_BITS;
    end
  end

  // row addressing, sync dominant
  always_ff @(posedge clk) begin
    if (reset) begin
      row_addr_ff  <= srrc_pkg::ADDR_ZERO;
      frame_end_ff <= 1'b0;
    end else if (cy_r) begin
      if (sy) begin
        row_addr_ff  <= row_start;
        frame_end_ff <= 1'b0;
      end else if (!frame_end_ff) begin
        if (cfg_ff[srrc_pkg::YDIR_BIT]) begin
          row_addr_ff  <= row_addr_ff - srrc_pkg::ROW_STEP;
          frame_end_ff <= row_addr_ff == srrc_pkg::ROW_STEP;
        end else begin
          row_addr_ff  <= row_addr_ff + srrc_pkg::ROW_STEP;
          frame_end_ff <= row_addr_ff == srrc_pkg::ADDR_MAX - srrc_pkg::ROW_STEP;
        end
      end
    end
  end

  // column advance stalls while the fifo is full; a start address pushed on line sync is dropped when it is full
  assign col_go = cx_r && !sx && armed_ff && !line_end_ff && fifo_ready;
  always_ff @(posedge clk) begin
    if (reset) begin
      col_addr_ff <= srrc_pkg::ADDR_ZERO;
      armed_ff    <= 1'b0;
      line_end_ff <= 1'b0;
    end else if (cx_r && sx) begin
      col_addr_ff <= col_start;
      armed_ff    <= 1'b1;
      line_end_ff <= 1'b0;
    end else if (col_go) begin
      col_addr_ff <= col_next;
      if (cfg_ff[srrc_pkg::XDIR_BIT]) begin
        line_end_ff <= col_addr_ff < (col_step << 1);
      end else begin
        line_end_ff <= col_addr_ff > srrc_pkg::ADDR_MAX - (col_step << 1);
      end
    end else if (cy_r) begin
      armed_ff <= 1'b0;
    end
  end

  // set needs line sync low and clear needs it high, so a stalled edge and a new line sync never meet
  always_ff @(posedge clk) begin
    if (reset) begin
      overrun_ff <= 1'b0;
    end else if (cx_r && !sx && armed_ff && !line_end_ff && !fifo_ready) begin
      overrun_ff <= 1'b1;
    end else if (cx_r && sx) begin
      overrun_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pixel_phase_ff <= 1'b0;
    end else begin
      pixel_phase_ff <= armed_ff && cx;
    end
  end

  // row overhead sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      row_st_ff   <= srrc_pkg::RP_IDLE;
      hold_cnt_ff <= srrc_pkg::ROT_ZERO;
    end else begin
      unique case (row_st_ff)
        // a new row may start from the held window without any pixel read
        srrc_pkg::RP_IDLE, srrc_pkg::RP_HELD, srrc_pkg::RP_READ: begin
          if (nrs_r || pc_r) begin
            row_st_ff   <= sh ? srrc_pkg::RP_TRACK : srrc_pkg::RP_READ;
            hold_cnt_ff <= srrc_pkg::ROT_ONE;
          end else if (row_st_ff == srrc_pkg::RP_HELD && cx_r) begin
            row_st_ff <= srrc_pkg::RP_READ;
          end
        end
        srrc_pkg::RP_TRACK: begin
          if (hold_fall) begin
            row_st_ff <= srrc_pkg::RP_HELD;
          end else if (hold_cnt_ff != srrc_pkg::ROT_TOP) begin
            hold_cnt_ff <= hold_cnt_ff + srrc_pkg::ROT_ONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      column_tracking_ff   <= 1'b0;
      rot_mode_ff          <= srrc_pkg::ROT_STANDARD;
      row_overhead_time_ff <= srrc_pkg::ROT_ZERO;
      hold_range_err_ff    <= 1'b0;
    end else begin
      column_tracking_ff <= sh;
      if (row_st_ff == srrc_pkg::RP_TRACK && !sh) begin
        rot_mode_ff          <= srrc_pkg::ROT_SAMPLE_HOLD;
        row_overhead_time_ff <= hold_cnt_ff;
        hold_range_err_ff    <= (hold_cnt_ff < srrc_pkg::ROT_W'(srrc_pkg::SH_MIN_CYC)) ||
                                (hold_cnt_ff > srrc_pkg::ROT_W'(srrc_pkg::SH_MAX_CYC));
      end else if (row_st_ff != srrc_pkg::RP_TRACK && (nrs_r || pc_r) && !sh) begin
        rot_mode_ff <= srrc_pkg::ROT_STANDARD;
      end
    end
  end

  // averaging only lands in the held window of a sample-and-hold row
  always_ff @(posedge clk) begin
    if (reset) begin
      avg_apply_ff   <= 1'b0;
      avg_refused_ff <= 1'b0;
    end else begin
      avg_apply_ff   <= va_r && cfg_ff[srrc_pkg::XAVG_BIT] && row_st_ff == srrc_pkg::RP_HELD;
      avg_refused_ff <= va_r && !(cfg_ff[srrc_pkg::XAVG_BIT] && row_st_ff == srrc_pkg::RP_HELD);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_precharged_ff <= 1'b0;
    end else begin
      bus_precharged_ff <= (pa_r && pb) || (pb_r && pa);
    end
  end

  srrc_fifo #(.W(srrc_pkg::ADDR_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk          (clk),
    .reset        (reset),
    .in_valid     (col_go || (cx_r && sx)),
    .in_ready     (fifo_ready),
    .in_data      ({cfg_ff[srrc_pkg::NOUT_BIT], col_go ? col_next : col_start}),
    .out_valid_ff (pix_valid_ff),
    .out_ready    (pix_ready),
    .out_data_ff  (pix_data_ff)
  );

  a_cfg_load: assert property (@(posedge clk) disable iff (reset) sld_r |=> cfg_ff == $past(shift_ff))
    else $error("config word not taken on load");
  a_spi_end: assert property (@(posedge clk) disable iff (reset)
    (sck_r && !sld && !sld_r) |=> spi_end_ff == $past(shift_ff[0]))
    else $error("shift end output wrong");
  a_col_init: assert property (@(posedge clk) disable iff (reset)
    (cx_r && sx) |=> col_addr_ff == {$past(cfg_ff[srrc_pkg::XADDR_LSB +: srrc_pkg::FIELD_W]), 1'b0})
    else $error("column start not loaded");
  a_row_init: assert property (@(posedge clk) disable iff (reset)
    (cy_r && sy) |=> row_addr_ff == {$past(cfg_ff[srrc_pkg::YADDR_LSB +: srrc_pkg::FIELD_W]), 1'b0})
    else $error("row start not loaded");
  a_row_down: assert property (@(posedge clk) disable iff (reset)
    (cy_r && !sy && !frame_end_ff && !cfg_ff[srrc_pkg::YDIR_BIT]) |=> row_addr_ff == $past(row_addr_ff) + 11'h001)
    else $error("top to bottom row step wrong");
  a_col_step: assert property (@(posedge clk) disable iff (reset)
    (col_go && !cfg_ff[srrc_pkg::XDIR_BIT]) |=> col_addr_ff == $past(col_addr_ff) + $past(col_step))
    else $error("left to right column step wrong");
  a_hold_time: assert property (@(posedge clk) disable iff (reset)
    (row_st_ff == srrc_pkg::RP_TRACK && !sh) |=> row_overhead_time_ff == $past(hold_cnt_ff))
    else $error("row overhead not captured");
  a_avg_gate: assert property (@(posedge clk) disable iff (reset)
    avg_apply_ff |-> $past(row_st_ff) == srrc_pkg::RP_HELD && $past(cfg_ff[srrc_pkg::XAVG_BIT]))
    else $error("averaging outside held window");
  a_phase: assert property (@(posedge clk) disable iff (reset) pixel_phase_ff |-> $past(cx) && $past(armed_ff))
    else $error("pixel phase not tied to pair clock");
  a_line_end: assert property (@(posedge clk) disable iff (reset) line_end_ff |=> !col_go)
    else $error("column advanced past line end");
endmodule // srrc_top

/* File: tb/srrc_ctrl_model.sv */
// camera controller model driving the sensor timing and serial pins
`timescale 1ns/1ps
module srrc_ctrl_model (
  input  wire logic clk,
  output logic      spi_clock,
  output logic      spi_data,
  output logic      spi_load,
  output logic      sync_y,
  output logic      clock_y,
  output logic      sync_x,
  output logic      clock_x,
  output logic      column_sample_hold,
  output logic      pre_col,
  output logic      norowsel,
  output logic      volt_avg,
  output logic      bus_precharge_a,
  output logic      bus_precharge_b
);
  initial begin
    {spi_clock, spi_data, spi_load, sync_y, clock_y, sync_x, clock_x} = 7'h00;
    {column_sample_hold, pre_col, norowsel, volt_avg, bus_precharge_a, bus_precharge_b} = 6'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data only moves while the shift clock is low
  task automatic shift(input logic [31:0] w, input int n);
    tick(1);
    for (int i = 0; i < n; i++) begin
      spi_data <= w[i];
      tick(3);
      spi_clock <= 1'b1;
      tick(3);
      spi_clock <= 1'b0;
    end
    tick(3);
  endtask
  task automatic load();
    tick(1);
    spi_load <= 1'b1;
    tick(4);
    spi_load <= 1'b0;
    tick(6);
  endtask
  // sync wraps a full clock pulse so the sensor sees one rising edge inside it
  task automatic row_step(input logic sync);
    tick(1);
    sync_y <= sync;
    tick(3);
    clock_y <= 1'b1;
    tick(4);
    clock_y <= 1'b0;
    tick(3);
    sync_y <= 1'b0;
    tick(4);
  endtask
  // pair clock kept slow: 50 MHz sampling cannot see the real rate
  task automatic col_step(input logic sync);
    tick(1);
    sync_x <= sync;
    tick(3);
    clock_x <= 1'b1;
    tick(4);
    clock_x <= 1'b0;
    tick(4);
    sync_x <= 1'b0;
    tick(4);
  endtask
  // hold_n of zero is the standard mode, hold stays low
  task automatic row_overhead(input int hold_n, input logic avg);
    tick(1);
    column_sample_hold <= (hold_n > 0);
    pre_col <= 1'b1;
    norowsel <= 1'b1;
    tick(3);
    pre_col <= 1'b0;
    norowsel <= 1'b0;
    tick((hold_n > 3) ? hold_n - 3 : 3);
    column_sample_hold <= 1'b0;
    tick(3);
    volt_avg <= avg;
    tick(3);
    volt_avg <= 1'b0;
    tick(6);
  endtask
  // held five cycles on a and three on b, a 5 ns pulse is unseen at this clock
  task automatic precharge();
    tick(1);
    bus_precharge_a <= 1'b1;
    tick(2);
    bus_precharge_b <= 1'b1;
    tick(3);
    bus_precharge_a <= 1'b0;
    bus_precharge_b <= 1'b0;
    tick(6);
  endtask
endmodule // srrc_ctrl_model

/* File: tb/tb.sv */
// self-checking bench for the sensor row readout and configuration block
`timescale 1ns/1ps
module tb;
  typedef struct {logic [31:0] word; logic [10:0] row; logic [10:0] col;} srrc_case_t;
  logic clk, reset, pix_ready;
  logic spi_clock, spi_data, spi_load, sync_y, clock_y, sync_x, clock_x;
  logic column_sample_hold, pre_col, norowsel, volt_avg, bus_precharge_a, bus_precharge_b;
  logic spi_end_ff, spi_count_err_ff, frame_end_ff, line_end_ff, pixel_phase_ff, overrun_ff;
  logic column_tracking_ff, hold_range_err_ff, avg_apply_ff, avg_refused_ff, bus_precharged_ff, pix_valid_ff;
  logic [31:0]         cfg_ff;
  logic [10:0]         row_addr_ff, col_addr_ff;
  srrc_pkg::srrc_rot_t rot_mode_ff;
  logic [7:0]          row_overhead_time_ff;
  logic [11:0]         pix_data_ff;
  int num_errors = 0;
  int num_checks = 0;
  int n_avg = 0;
  int n_ref = 0;
  int n_pre = 0;
  int n_trk = 0;
  int n_ph = 0;
  int ph0;
  int hold_len [4] = '{5, 10, 4, 11};
  srrc_case_t cases [4] = '{'{32'h0000_0000, 11'h000, 11'h000}, '{32'hFF01_4006, 11'h006, 11'h00A},
                            '{32'h00FF_C7FE, 11'h7FE, 11'h7FE}, '{32'h0000_9800, 11'h000, 11'h004}};
  srrc_ctrl_model ctl (.clk(clk), .spi_clock(spi_clock), .spi_data(spi_data), .spi_load(spi_load),
    .sync_y(sync_y), .clock_y(clock_y), .sync_x(sync_x), .clock_x(clock_x),
    .column_sample_hold(column_sample_hold), .pre_col(pre_col), .norowsel(norowsel), .volt_avg(volt_avg),
    .bus_precharge_a(bus_precharge_a), .bus_precharge_b(bus_precharge_b));
  srrc_top #(.FIFO_DEPTH(4)) dut (.clk(clk), .reset(reset), .spi_clock(spi_clock), .spi_data(spi_data),
    .spi_load(spi_load), .sync_y(sync_y), .clock_y(clock_y), .sync_x(sync_x), .clock_x(clock_x),
    .column_sample_hold(column_sample_hold), .pre_col(pre_col), .norowsel(norowsel), .volt_avg(volt_avg),
    .bus_precharge_a(bus_precharge_a), .bus_precharge_b(bus_precharge_b), .pix_ready(pix_ready),
    .spi_end_ff(spi_end_ff), .spi_count_err_ff(spi_count_err_ff), .cfg_ff(cfg_ff), .row_addr_ff(row_addr_ff),
    .frame_end_ff(frame_end_ff), .col_addr_ff(col_addr_ff), .line_end_ff(line_end_ff),
    .pixel_phase_ff(pixel_phase_ff), .overrun_ff(overrun_ff), .column_tracking_ff(column_tracking_ff),
    .rot_mode_ff(rot_mode_ff), .row_overhead_time_ff(row_overhead_time_ff),
    .hold_range_err_ff(hold_range_err_ff), .avg_apply_ff(avg_apply_ff), .avg_refused_ff(avg_refused_ff),
    .bus_precharged_ff(bus_precharged_ff), .pix_valid_ff(pix_valid_ff), .pix_data_ff(pix_data_ff));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // one-cycle pulses are counted rather than caught by timing
  always @(posedge clk) begin
    n_avg <= n_avg + (avg_apply_ff === 1'b1);
    n_ref <= n_ref + (avg_refused_ff === 1'b1);
    n_pre <= n_pre + (bus_precharged_ff === 1'b1);
    n_trk <= n_trk + (column_tracking_ff === 1'b1);
    n_ph  <= n_ph + (pixel_phase_ff === 1'b1);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic load(input logic [31:0] w);
    ctl.shift(w, 32);
    ctl.load();
    @(negedge clk);
  endtask
  task automatic pop(input logic [11:0] exp);
    int n;
    n = 0;
    @(negedge clk);
    while (pix_valid_ff !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check(pix_valid_ff, 1'b1);
    check(pix_data_ff, exp);
    @(posedge clk);
    pix_ready <= 1'b1;
    @(posedge clk);
    pix_ready <= 1'b0;
  endtask
  task automatic drain();
    @(posedge clk);
    pix_ready <= 1'b1;
    repeat (12) @(posedge clk);
    pix_ready <= 1'b0;
  endtask
  initial begin
    #1_000_000;
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    give_verdict();
  end
  initial begin
    reset = 1'b1;
    pix_ready = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check(cfg_ff, 32'h0000_0000);
    check(pix_valid_ff, 1'b0);
    foreach (cases[i]) begin
      load(cases[i].word);
      check(cfg_ff, cases[i].word);
      ctl.row_step(1'b1);
      @(negedge clk);
      check(row_addr_ff, cases[i].row);
      ctl.col_step(1'b1);
      pop({cases[i].word[24], cases[i].col});
    end
    // subsampled step moves by four and hands out the new address
    ph0 = n_ph;
    ctl.col_step(1'b0);
    check(n_ph - ph0, 4);
    pop(12'h008);
    check(col_addr_ff, 11'h008);
    load(32'h0000_07FE);
    ctl.row_step(1'b1);
    ctl.row_step(1'b0);
    ctl.row_step(1'b0);
    @(negedge clk);
    check(row_addr_ff, 11'h7FF);
    check(frame_end_ff, 1'b1);
    load(32'h0000_0003);
    ctl.row_step(1'b1);
    @(negedge clk);
    check(frame_end_ff, 1'b0);
    ctl.row_step(1'b0);
    ctl.row_step(1'b0);
    @(negedge clk);
    check(row_addr_ff, 11'h000);
    check(frame_end_ff, 1'b1);
    load(32'h0000_6000);
    ctl.col_step(1'b1);
    ctl.col_step(1'b0);
    ctl.col_step(1'b0);
    @(negedge clk);
    check(col_addr_ff, 11'h000);
    check(line_end_ff, 1'b1);
    drain();
    // stall the drain side until the buffer refuses
    load(32'h0000_0000);
    ctl.col_step(1'b1);
    repeat (6) ctl.col_step(1'b0);
    @(negedge clk);
    check(overrun_ff, 1'b1);
    for (int k = 0; k < 5; k++) pop(12'(2 * k));
    drain();
    ctl.col_step(1'b1);
    @(negedge clk);
    check(overrun_ff, 1'b0);
    drain();
    @(negedge clk);
    check(pix_valid_ff, 1'b0);
    load(32'h8000_0001);
    ctl.shift(32'h0000_0000, 1);
    @(negedge clk);
    check(spi_end_ff, 1'b1);
    load(32'h0000_0800);
    check(spi_count_err_ff, 1'b1);
    check(cfg_ff, 32'h0000_0800);
    load(32'h0000_0800);
    check(spi_count_err_ff, 1'b0);
    ctl.row_overhead(7, 1'b1);
    @(negedge clk);
    check(rot_mode_ff, srrc_pkg::ROT_SAMPLE_HOLD);
    check(n_avg, 1);
    foreach (hold_len[i]) begin
      ctl.row_overhead(hold_len[i], 1'b0);
      @(negedge clk);
      check(row_overhead_time_ff, hold_len[i]);
      check(hold_range_err_ff, hold_len[i] < 5 || hold_len[i] > 10);
    end
    ctl.row_overhead(0, 1'b1);
    @(negedge clk);
    check(rot_mode_ff, srrc_pkg::ROT_STANDARD);
    load(32'h0000_0000);
    ctl.row_overhead(7, 1'b1);
    @(negedge clk);
    check(n_ref, 2);
    check(n_avg, 1);
    ctl.precharge();
    @(negedge clk);
    check(n_pre, 1);
    check(n_trk, 44);
    give_verdict();
  end
endmodule // tb
